// File: core/tsq_params.svh
`ifndef TSQ_PARAMS_SVH
`define TSQ_PARAMS_SVH

// Shared tag bus geometry
`define TSQ_TBUS_W        40
`define TSQ_TAG_W         20
`define TSQ_CMP_HI        17
`define TSQ_CMP_LO        7
`define TSQ_CMP_W         11
`define TSQ_INDEX_HI      19
`define TSQ_INDEX_LO      5

// Combined read return layout
`define TSQ_COMB_HI       37
`define TSQ_COMB_LO       18
`define TSQ_ODD_DIRTY_HI  37
`define TSQ_ODD_DIRTY_LO  34
`define TSQ_EVEN_DIRTY_HI 21
`define TSQ_EVEN_DIRTY_LO 18

// Tag ram word: dirty 19:16, synonym 15:12, sector states 11:4, unused 3:0
`define TSQ_RAM_DIRTY_HI  19
`define TSQ_RAM_DIRTY_LO  16
`define TSQ_RAM_VS_HI     15
`define TSQ_RAM_VS_LO     4

// State read timing, in clocks counted from the function field (clock 2)
`define TSQ_RD_TRI_CLK    5
`define TSQ_RD_CAP_CLK    6
`define TSQ_RD_OWN_CLK    8
`define TSQ_RD_RET_CLK    9
`define TSQ_RD_END_CLK    10

// Store queue compare latency in clocks
`define TSQ_CMP_LAT       4

// Function codes
`define TSQ_FN_W          3
`define TSQ_FN_NOP        3'h0
`define TSQ_FN_RD_EVEN    3'h1
`define TSQ_FN_RD_ODD     3'h2
`define TSQ_FN_RD_COMB    3'h3
`define TSQ_FN_SQ_CMP     3'h4
`define TSQ_FN_EMPTY_Q    3'h5

`endif

// File: core/tsq_pkg.sv
package tsq_pkg;

  typedef enum logic [2:0] {
    TSQ_IDLE = 3'b001,
    TSQ_READ = 3'b010,
    TSQ_EMPT = 3'b100
  } tsq_state_e;

  typedef struct packed {
    logic [39:0] data;
    logic        oe;
  } tsq_bus_out_s;

  typedef struct packed {
    logic        valid;
    logic [10:0] addr;
  } tsq_cmp_s;

endpackage

// File: core/tsq_tag_state_read.sv
// Behaviour
// - Release tag address bus in clock five
// - Capture tag data, retake tag bus clock eight
// - Return on shared bus clock nine, release ten
// - Drive all forty bits on return
// - Combined read lands on bits 37:18
// - Combined: odd state and synonym, even dirty
// - Odd dirty 37:34, synonym, states, 39:38 undefined
// - Even dirty 21:18, bits 17:0 undefined
// - Compare address bits 17:7 only
// - Compare both queues within four clocks
// - Results on two active-low pins only
// - Drain queue, then assert release
// - Sector false positives still honoured
// - Compares pipelined, one per clock
`timescale 1ns/100ps
`default_nettype none
`include "tsq_params.svh"

module tsq_tag_state_read #(
  parameter int QDEPTH = 8
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // Shared tag bus from controller
  input  wire logic [`TSQ_TBUS_W-1:0]    tbus_in,
  input  wire logic [`TSQ_FN_W-1:0]      func_in,
  // Shared tag bus drive
  output logic      [`TSQ_TBUS_W-1:0]    tbus_out,
  output logic                           tbus_oe,
  // Tag ram data bus, odd and even
  input  wire logic [`TSQ_TAG_W-1:0]     odd_tag_in,
  input  wire logic [`TSQ_TAG_W-1:0]     even_tag_in,
  output logic                           tag_addr_oe,
  // Store address queue entries and state
  input  wire logic [QDEPTH*`TSQ_CMP_W-1:0] left_queue_addr,
  input  wire logic [QDEPTH-1:0]         left_queue_valid,
  input  wire logic [QDEPTH*`TSQ_CMP_W-1:0] right_queue_addr,
  input  wire logic [QDEPTH-1:0]         right_queue_valid,
  input  wire logic                      queue_empty,
  output logic                           queue_drain_req,
  // Match pins and bus handoff
  output logic                           even_queue_match_n,
  output logic                           odd_queue_match_n,
  output logic                           processor_bus_release_n
);

  initial begin
    if (QDEPTH < 1 || QDEPTH > 64) begin
      $error("QDEPTH out of range");
    end
  end

  tsq_pkg::tsq_state_e state_reg;
  logic [3:0]          rd_cnt_reg;
  logic                rd_comb_reg;
  logic                rd_even_reg;
  logic [`TSQ_TAG_W-1:0] odd_cap_reg;
  logic [`TSQ_TAG_W-1:0] even_cap_reg;
  logic [`TSQ_TBUS_W-1:0] ret_word;

  wire logic rd_start = (func_in == `TSQ_FN_RD_EVEN) || (func_in == `TSQ_FN_RD_ODD)
                     || (func_in == `TSQ_FN_RD_COMB);

  // State read sequencer; controller guarantees no competing cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg   <= tsq_pkg::TSQ_IDLE;
      rd_cnt_reg  <= 4'h0;
      rd_comb_reg <= 1'b0;
      rd_even_reg <= 1'b0;
    end else begin
      case (state_reg)
        tsq_pkg::TSQ_IDLE: begin
          if (func_in == `TSQ_FN_EMPTY_Q) begin
            state_reg <= tsq_pkg::TSQ_EMPT;
          end else if (rd_start) begin
            state_reg   <= tsq_pkg::TSQ_READ;
            rd_cnt_reg  <= 4'h3;
            rd_comb_reg <= (func_in == `TSQ_FN_RD_COMB);
            rd_even_reg <= (func_in == `TSQ_FN_RD_EVEN);
          end
        end
        tsq_pkg::TSQ_READ: begin
          rd_cnt_reg <= rd_cnt_reg + 4'h1;
          if (rd_cnt_reg == 4'(`TSQ_RD_END_CLK)) begin
            state_reg <= tsq_pkg::TSQ_IDLE;
          end
        end
        tsq_pkg::TSQ_EMPT: begin
          if (!processor_bus_release_n) begin
            state_reg <= tsq_pkg::TSQ_IDLE;
          end
        end
        default: state_reg <= tsq_pkg::TSQ_IDLE;
      endcase
    end
  end

  // Tag address bus released in clock 5, retaken in clock 8
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tag_addr_oe <= 1'b1;
    end else if (state_reg == tsq_pkg::TSQ_READ
                 && rd_cnt_reg == 4'(`TSQ_RD_TRI_CLK - 1)) begin
      tag_addr_oe <= 1'b0;
    end else if (state_reg == tsq_pkg::TSQ_READ
                 && rd_cnt_reg == 4'(`TSQ_RD_OWN_CLK - 1)) begin
      tag_addr_oe <= 1'b1;
    end
  end

  // Capture tag ram data driven in clock 6
  always_ff @(posedge clock) begin
    if (!nrst) begin
      odd_cap_reg  <= '0;
      even_cap_reg <= '0;
    end else if (state_reg == tsq_pkg::TSQ_READ
                 && rd_cnt_reg == 4'(`TSQ_RD_CAP_CLK)) begin
      odd_cap_reg  <= odd_tag_in;
      even_cap_reg <= even_tag_in;
    end
  end

  // Return word; undefined fields are zero
  always_comb begin
    ret_word = '0;
    if (rd_comb_reg) begin
      ret_word[`TSQ_COMB_HI:`TSQ_COMB_LO] = odd_cap_reg;
      ret_word[`TSQ_ODD_DIRTY_HI:`TSQ_ODD_DIRTY_LO] =
        odd_cap_reg[`TSQ_RAM_DIRTY_HI:`TSQ_RAM_DIRTY_LO];
      ret_word[`TSQ_EVEN_DIRTY_HI:`TSQ_EVEN_DIRTY_LO] =
        even_cap_reg[`TSQ_RAM_DIRTY_HI:`TSQ_RAM_DIRTY_LO];
    end else begin
      // Single read: only the addressed ram counts, the other bus may hold junk
      ret_word[`TSQ_COMB_HI:`TSQ_COMB_LO] = rd_even_reg ? even_cap_reg : odd_cap_reg;
      ret_word[21:18] = 4'h0;
    end
  end

  // Shared bus driven in clock 9 only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tbus_oe  <= 1'b0;
      tbus_out <= '0;
    end else if (state_reg == tsq_pkg::TSQ_READ
                 && rd_cnt_reg == 4'(`TSQ_RD_RET_CLK - 1)) begin
      tbus_oe  <= 1'b1;
      tbus_out <= ret_word;
    end else begin
      tbus_oe  <= 1'b0;
      tbus_out <= '0;
    end
  end

  // Compare pipeline: slot per clock, result four clocks after issue
  tsq_pkg::tsq_cmp_s cmp_pipe [0:`TSQ_CMP_LAT-2];
  logic [QDEPTH-1:0] left_hit;
  logic [QDEPTH-1:0] right_hit;

  genvar gi;
  generate
    for (gi = 0; gi < QDEPTH; gi++) begin : g_cmp
      assign left_hit[gi]  = left_queue_valid[gi] && (cmp_pipe[`TSQ_CMP_LAT-2].addr
        == left_queue_addr[gi*`TSQ_CMP_W +: `TSQ_CMP_W]);
      assign right_hit[gi] = right_queue_valid[gi] && (cmp_pipe[`TSQ_CMP_LAT-2].addr
        == right_queue_addr[gi*`TSQ_CMP_W +: `TSQ_CMP_W]);
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < `TSQ_CMP_LAT-1; i++) begin
        cmp_pipe[i] <= '0;
      end
    end else begin
      cmp_pipe[0].valid <= (func_in == `TSQ_FN_SQ_CMP);
      cmp_pipe[0].addr  <= tbus_in[`TSQ_CMP_HI:`TSQ_CMP_LO];
      for (int i = 1; i < `TSQ_CMP_LAT-1; i++) begin
        cmp_pipe[i] <= cmp_pipe[i-1];
      end
    end
  end

  // Pins are independent; nothing returns on the shared bus
  always_ff @(posedge clock) begin
    if (!nrst) begin
      even_queue_match_n <= 1'b1;
      odd_queue_match_n  <= 1'b1;
    end else begin
      even_queue_match_n <= !(cmp_pipe[`TSQ_CMP_LAT-2].valid && |left_hit);
      odd_queue_match_n  <= !(cmp_pipe[`TSQ_CMP_LAT-2].valid && |right_hit);
    end
  end

  // Stores drain to completion, never flushed
  always_ff @(posedge clock) begin
    if (!nrst) begin
      queue_drain_req         <= 1'b0;
      processor_bus_release_n <= 1'b1;
    end else begin
      queue_drain_req         <= (state_reg == tsq_pkg::TSQ_EMPT)
                                 && processor_bus_release_n;
      processor_bus_release_n <= !((state_reg == tsq_pkg::TSQ_EMPT)
                                   && processor_bus_release_n && queue_empty);
    end
  end

endmodule

`default_nettype wire

// File: tb/tsq_props.sv
`timescale 1ns/100ps
`default_nettype none
module tsq_props #(
  parameter int QDEPTH = 8
) (
  // Clock, reset, controller side
  input wire logic                 clock,
  input wire logic                 nrst,
  input wire logic [39:0]          tbus_in,
  input wire logic [2:0]           func_in,
  // Device side
  input wire logic [39:0]          tbus_out,
  input wire logic                 tbus_oe,
  input wire logic [19:0]          odd_tag_in,
  input wire logic [19:0]          even_tag_in,
  input wire logic                 tag_addr_oe,
  input wire logic [QDEPTH*11-1:0] left_queue_addr,
  input wire logic [QDEPTH-1:0]    left_queue_valid,
  input wire logic [QDEPTH*11-1:0] right_queue_addr,
  input wire logic [QDEPTH-1:0]    right_queue_valid,
  input wire logic                 queue_empty,
  input wire logic                 queue_drain_req,
  input wire logic                 even_queue_match_n,
  input wire logic                 odd_queue_match_n,
  input wire logic                 processor_bus_release_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic lhit;
  logic rhit;
  always_comb begin
    lhit = 1'b0;
    rhit = 1'b0;
    for (int i = 0; i < QDEPTH; i++) begin
      lhit |= left_queue_valid[i] && left_queue_addr[i*11+:11] == tbus_in[17:7];
      rhit |= right_queue_valid[i] && right_queue_addr[i*11+:11] == tbus_in[17:7];
    end
  end
  AST_TAG_RELEASE: assert property ($fell(tag_addr_oe) |-> $past(func_in, 3) inside {3'h1, 3'h2, 3'h3})
    else $error("tag bus released off slot");
  AST_TAG_RETAKE: assert property ($fell(tag_addr_oe) |-> !tag_addr_oe [*3] ##1 tag_addr_oe)
    else $error("tag bus not retaken");
  AST_RETURN_SLOT: assert property ($rose(tbus_oe) |-> $past(func_in, 7) inside {3'h1, 3'h2, 3'h3})
    else $error("return off slot");
  AST_RETURN_ONE: assert property (tbus_oe |=> !tbus_oe)
    else $error("shared bus held too long");
  AST_UNDEF_ZERO: assert property (tbus_oe |-> tbus_out[39:38] == 2'h0 && tbus_out[17:0] == 18'h0)
    else $error("undefined bits not zero");
  AST_COMB_LAYOUT: assert property (tbus_oe && $past(func_in, 7) == 3'h3 |->
    {tbus_out[37:22], 4'h0} == ($past(odd_tag_in, 3) & 20'hf_fff0)
    && tbus_out[21:18] == 4'($past(even_tag_in, 3) >> 16)) else $error("combined layout wrong");
  AST_LEFT_MATCH: assert property (even_queue_match_n == !($past(func_in, 4) == 3'h4 && $past(lhit, 4)))
    else $error("left match wrong");
  AST_RIGHT_MATCH: assert property (odd_queue_match_n == !($past(func_in, 4) == 3'h4 && $past(rhit, 4)))
    else $error("right match wrong");
  AST_RELEASE: assert property (!processor_bus_release_n |->
    $past(queue_empty) && $past(queue_drain_req) ##1 processor_bus_release_n) else $error("bad release");
  cover property (tbus_oe);
  cover property (!even_queue_match_n);
  cover property (!processor_bus_release_n);
endmodule
bind tsq_tag_state_read tsq_props #(.QDEPTH(QDEPTH)) u_tsq_props (.*);
`default_nettype wire

// File: tb/tsq_tag_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module tsq_tag_ram_model (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Tag bus
  input wire logic        tag_addr_oe,
  input wire logic [39:0] words,
  output logic     [19:0] odd_tag_in,
  output logic     [19:0] even_tag_in
);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      {odd_tag_in, even_tag_in} <= '0;
    end else if (!tag_addr_oe) begin
      {odd_tag_in, even_tag_in} <= words;
    end else begin
      // Address bus driven (tag_addr_oe high): never leave a stale word
      {odd_tag_in, even_tag_in} <= ~{odd_tag_in, even_tag_in};
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [39:0] tbus_in = '0;
  logic [2:0]  func_in = '0;
  logic [39:0] words = 40'hb6_d5a3_9e71;
  logic [87:0] left_queue_addr = '0;
  logic [87:0] right_queue_addr = '0;
  logic [7:0]  left_queue_valid = '0;
  logic [7:0]  right_queue_valid = '0;
  logic        queue_empty = 1'b0;
  logic [39:0] tbus_out;
  logic [19:0] odd_tag_in;
  logic [19:0] even_tag_in;
  logic        tbus_oe;
  logic        tag_addr_oe;
  logic        queue_drain_req;
  logic        even_queue_match_n;
  logic        odd_queue_match_n;
  logic        processor_bus_release_n;
  int          errors = 0;
  int          tests_run = 0;
  tsq_tag_state_read u_tsq_tag_state_read (.*);
  tsq_tag_ram_model u_tsq_tag_ram_model (.*);
  always #50 clock = ~clock;
  task automatic tick(); @(posedge clock); #1; endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_read(input logic [2:0] fn, input logic [39:0] exp);
    int n;
    func_in = fn;
    tbus_in = {20'h0, 15'h25a5, 5'h0};
    tick();
    func_in = 3'h0;
    if (fn != 3'h3) tbus_in = '0;
    for (n = 1; n < 12 && tbus_oe !== 1'b1; n++) begin
      chk(tag_addr_oe, 40'(n < 3 || n > 5));
      tick();
      tbus_in = '0;
    end
    chk(n, 7);
    chk(tbus_out, exp);
    tick();
    chk(tbus_oe, 0);
    tick();
    $display("read %0d done", fn);
    if (n >= 12) finish_test();
  endtask
  task automatic t_cmp();
    logic [10:0] addr [5] = '{11'h123, 11'h456, 11'h124, 11'h0, 11'h0};
    logic [1:0]  exp [5] = '{2'b01, 2'b10, 2'b11, 2'b11, 2'b11};
    left_queue_addr[22+:11] = 11'h123;
    left_queue_addr[0+:11] = 11'h456;
    left_queue_valid = 8'h04;
    right_queue_addr[55+:11] = 11'h456;
    right_queue_valid = 8'h20;
    for (int i = 0; i < 8; i++) begin
      func_in = (i < 3) ? 3'h4 : 3'h0;
      tbus_in = {22'h0, addr[i % 5], 7'(i * 41)};
      tick();
      if (i >= 3) chk({even_queue_match_n, odd_queue_match_n}, exp[i-3]);
    end
    $display("compare done");
  endtask
  task automatic t_empty();
    int n;
    func_in = 3'h5;
    tick();
    func_in = 3'h0;
    for (n = 0; n < 4 && queue_drain_req !== 1'b1; n++) tick();
    repeat (3) tick();
    chk({queue_drain_req, processor_bus_release_n}, 3);
    queue_empty = 1'b1;
    for (n = 0; n < 4 && processor_bus_release_n !== 1'b0; n++) tick();
    chk(processor_bus_release_n, 0);
    tick();
    chk(processor_bus_release_n, 1);
    $display("empty queue done");
    if (n >= 4) finish_test();
  endtask
  initial begin
    repeat (2) tick();
    nrst = 1'b1;
    chk(tbus_out, 40'h0);
    chk({tbus_oe, tag_addr_oe, queue_drain_req, even_queue_match_n,
         odd_queue_match_n, processor_bus_release_n}, 40'h17);
    $display("reset done");
    t_read(3'h2, {2'h0, words[39:24], 22'h0});
    t_read(3'h1, {2'h0, words[19:4], 22'h0});
    t_read(3'h3, {2'h0, words[39:24], words[19:16], 18'h0});
    t_cmp();
    t_empty();
    finish_test();
  end
endmodule
`default_nettype wire
